// file: src/byte_divider.sv
`timescale 1ns/100ps
// ****************************************
// Unsigned 8-bit divider
// ****************************************
module byte_divider
    import exec_pkg::*;
(
    // Operands
    input wire logic [7:0] dividend,
    input wire logic [7:0] divisor,
    // Results
    output logic [7:0] quotient,
    output logic [7:0] remainder,
    output logic by_zero
);
    // Restoring division; zero divisor gives all-ones quotient, left undefined to software
    always_comb begin
        logic [8:0] rem;
        rem = 9'h000;
        quotient = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            rem = {rem[7:0], dividend[i]};
            if (rem >= {1'b0, divisor}) begin
                rem = rem - {1'b0, divisor};
                quotient[i] = 1'b1;
            end
        end
        remainder = rem[7:0];
        by_zero = (divisor == 8'h00);
    end
endmodule

// file: src/dec_inc_div_branch_exec.sv
`timescale 1ns/100ps
// How it works
// - Minus-one subtracts one, 00H wraps to 0FFH, flags untouched.
// - Minus-one operand is accumulator, bank register, direct byte or indirect byte.
// - Read-modify-write on a port takes the output latch, not pins.
// - Minus-one opcodes 14H, 18H-1FH, 15H+addr, 16H/17H; one cycle each.
// - Divide A by B: quotient to A, remainder to B, clear C and excess; 4 cycles.
// - Divisor zero sets excess flag, clears carry; results undefined.
// - Loop-count branch decrements with wrap, branches on non-zero, no flags.
// - Loop branch target is advanced PC plus signed last byte.
// - Loop branch register form 2 bytes, direct 3 bytes, 2 cycles each.
// - Loop branch register form decoded from 11011rrr plus offset.
// - Plus-one adds one, 0FFH wraps to 00H, flags untouched.
// - Data-pointer increment is 16-bit modulo, low carries into high; 2 cycles.
// - Branch-on-bit-set jumps when bit is one; bit and flags unchanged.
// - Bit branch target is advanced PC plus signed third byte.
// - Bit branch opcode 20H, bit address, offset; 3 bytes, 2 cycles.
module dec_inc_div_branch_exec
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Instruction issue
    input wire logic issue,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [7:0] operand2,
    input wire logic [15:0] pc_in,
    // Operand values fetched by the core
    input wire logic [7:0] acc_in,
    input wire logic [7:0] b_in,
    input wire logic [7:0] bank_work_reg_in,
    input wire logic [7:0] mem_in,
    input wire logic [7:0] port_latch_in,
    input wire logic is_port,
    input wire logic bit_in,
    input wire logic [7:0] pointer_low_byte_in,
    input wire logic [7:0] pointer_high_byte_in,
    input wire logic carry_in,
    input wire logic arith_excess_flag_in,
    // Results
    output logic busy,
    output logic done,
    output logic [15:0] pc_out,
    output logic acc_we,
    output logic [7:0] acc_out,
    output logic b_we,
    output logic [7:0] b_out,
    output logic byte_we,
    output logic [1:0] byte_dest,
    output logic [7:0] byte_out,
    output logic ptr_we,
    output logic [7:0] pointer_low_byte_out,
    output logic [7:0] pointer_high_byte_out,
    output logic flags_we,
    output logic carry_out,
    output logic arith_excess_flag_out,
    output logic illegal
);
    // ****************************************
    // Decoding
    // ****************************************
    typedef enum {OP_NONE, OP_MINUS, OP_PLUS, OP_DIVIDE, OP_LOOP, OP_PTR, OP_BIT} op_e;
    typedef enum {ST_IDLE, ST_WAIT} state_e;

    // Destination codes for byte results
    localparam logic [1:0] DST_ACC = 2'h0;
    localparam logic [1:0] DST_BANK = 2'h1;
    localparam logic [1:0] DST_DIR = 2'h2;
    localparam logic [1:0] DST_IND = 2'h3;

    // Classify the operand source of a one-byte arithmetic opcode
    function automatic logic [1:0] byte_src(input logic [7:0] op);
        if (op[3])
            byte_src = DST_BANK;
        else if (op[1])
            byte_src = DST_IND;
        else if (op[0])
            byte_src = DST_DIR;
        else
            byte_src = DST_ACC;
    endfunction

    // Branch target: advanced PC plus sign-extended displacement
    function automatic logic [15:0] rel_target(input logic [15:0] next_pc, input logic [7:0] rel);
        rel_target = next_pc + {{8{rel[7]}}, rel};
    endfunction

    op_e op_kind;
    logic [15:0] op_len;
    logic [2:0] op_cycles;
    logic [1:0] src_kind;

    // Decoder for the opcodes this unit owns
    always_comb begin
        op_kind = OP_NONE;
        op_len = LEN_ONE;
        op_cycles = CYC_ONE;
        src_kind = byte_src(opcode);
        if (opcode == OP_DEC_A || opcode == OP_DEC_DIR || opcode[7:1] == OP_DEC_IND
            || opcode[7:3] == OP_DEC_REG) begin
            op_kind = OP_MINUS;
            op_len = (opcode == OP_DEC_DIR) ? LEN_TWO : LEN_ONE;
        end else if (opcode == OP_INC_A || opcode == OP_INC_DIR || opcode[7:1] == OP_INC_IND
            || opcode[7:3] == OP_INC_REG) begin
            op_kind = OP_PLUS;
            op_len = (opcode == OP_INC_DIR) ? LEN_TWO : LEN_ONE;
        end else if (opcode == OP_DIV) begin
            op_kind = OP_DIVIDE;
            op_cycles = CYC_DIV;
        end else if (opcode[7:3] == OP_LOOP_REG) begin
            op_kind = OP_LOOP;
            op_len = LEN_TWO;
            op_cycles = CYC_TWO;
            src_kind = DST_BANK;
        end else if (opcode == OP_LOOP_DIR) begin
            op_kind = OP_LOOP;
            op_len = LEN_THREE;
            op_cycles = CYC_TWO;
            src_kind = DST_DIR;
        end else if (opcode == OP_INC_PTR) begin
            op_kind = OP_PTR;
            op_cycles = CYC_TWO;
        end else if (opcode == OP_BIT_SET) begin
            op_kind = OP_BIT;
            op_len = LEN_THREE;
            op_cycles = CYC_TWO;
        end
    end

    // ****************************************
    // Datapath
    // ****************************************
    logic [7:0] operand_val;
    logic [7:0] minus_val;
    logic [7:0] plus_val;
    logic [15:0] ptr_sum;
    logic [15:0] next_pc;
    logic [7:0] quo;
    logic [7:0] rem;
    logic div_zero;

    // Port targets read the output latch so pin loading cannot corrupt the result
    always_comb begin
        case (src_kind)
            DST_ACC: operand_val = acc_in;
            DST_BANK: operand_val = bank_work_reg_in;
            default: operand_val = is_port ? port_latch_in : mem_in;
        endcase
    end

    assign minus_val = operand_val - 8'h01;
    assign plus_val = operand_val + 8'h01;
    assign ptr_sum = {pointer_high_byte_in, pointer_low_byte_in} + 16'h0001;
    assign next_pc = pc_in + op_len;

    byte_divider u_div (
        .dividend(acc_in),
        .divisor(b_in),
        .quotient(quo),
        .remainder(rem),
        .by_zero(div_zero)
    );

    // ****************************************
    // Sequencing
    // ****************************************
    state_e state_reg;
    logic [2:0] count_reg;

    // Multi-cycle instructions hold busy until their cycle count is used up
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            count_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (issue && op_kind != OP_NONE && op_cycles != CYC_ONE) begin
                        state_reg <= ST_WAIT;
                        count_reg <= op_cycles - 3'h1;
                    end
                end
                ST_WAIT: begin
                    count_reg <= count_reg - 3'h1;
                    if (count_reg == 3'h1)
                        state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Busy output follows the sequencer
    always_ff @(posedge clock) begin
        if (sys_rst)
            busy <= 1'b0;
        else if (state_reg == ST_IDLE)
            busy <= issue && op_kind != OP_NONE && op_cycles != CYC_ONE;
        else
            busy <= count_reg != 3'h1;
    end

    // ****************************************
    // Result registers
    // ****************************************
    // Results are computed at issue and held; writes strobe two cycles after the final cycle.
    // Operands must stay valid only in the issue cycle.
    logic [7:0] acc_hold;
    logic [7:0] b_hold;
    logic [7:0] byte_hold;
    logic [15:0] pc_hold;
    logic [15:0] ptr_hold;
    logic acc_w_hold;
    logic b_w_hold;
    logic byte_w_hold;
    logic ptr_w_hold;
    logic flags_w_hold;
    logic excess_hold;
    logic [1:0] dest_hold;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            acc_hold <= BYTE_RESET;
            b_hold <= BYTE_RESET;
            byte_hold <= BYTE_RESET;
            pc_hold <= PC_RESET;
            ptr_hold <= PC_RESET;
            acc_w_hold <= 1'b0;
            b_w_hold <= 1'b0;
            byte_w_hold <= 1'b0;
            ptr_w_hold <= 1'b0;
            flags_w_hold <= 1'b0;
            excess_hold <= 1'b0;
            dest_hold <= DST_ACC;
        end else if (issue && state_reg == ST_IDLE) begin
            acc_hold <= acc_in;
            b_hold <= b_in;
            byte_hold <= operand_val;
            pc_hold <= next_pc;
            ptr_hold <= ptr_sum;
            acc_w_hold <= 1'b0;
            b_w_hold <= 1'b0;
            byte_w_hold <= 1'b0;
            ptr_w_hold <= 1'b0;
            flags_w_hold <= 1'b0;
            excess_hold <= arith_excess_flag_in;
            dest_hold <= src_kind;
            case (op_kind)
                OP_MINUS: begin
                    byte_hold <= minus_val;
                    byte_w_hold <= 1'b1;
                end
                OP_PLUS: begin
                    byte_hold <= plus_val;
                    byte_w_hold <= 1'b1;
                end
                OP_LOOP: begin
                    byte_hold <= minus_val;
                    byte_w_hold <= 1'b1;
                    if (minus_val != 8'h00)
                        pc_hold <= rel_target(next_pc, opcode == OP_LOOP_DIR ? operand2 : operand1);
                end
                OP_DIVIDE: begin
                    acc_hold <= quo;
                    b_hold <= rem;
                    acc_w_hold <= 1'b1;
                    b_w_hold <= 1'b1;
                    flags_w_hold <= 1'b1;
                    excess_hold <= div_zero;
                end
                OP_PTR: ptr_w_hold <= 1'b1;
                OP_BIT: begin
                    if (bit_in)
                        pc_hold <= rel_target(next_pc, operand2);
                end
                default: pc_hold <= pc_in;
            endcase
        end
    end

    // Final-cycle strobe: single-cycle ops finish the edge after issue
    logic finish;
    assign finish = (state_reg == ST_WAIT && count_reg == 3'h1)
        || (state_reg == ST_IDLE && issue && op_kind != OP_NONE && op_cycles == CYC_ONE);
    logic finish_reg;

    always_ff @(posedge clock) begin
        if (sys_rst)
            finish_reg <= 1'b0;
        else
            finish_reg <= finish;
    end

    // Unknown opcodes flagged for the outer decoder
    always_ff @(posedge clock) begin
        if (sys_rst)
            illegal <= 1'b0;
        else
            illegal <= issue && state_reg == ST_IDLE && op_kind == OP_NONE;
    end

    // Outputs registered two edges after the last cycle of each instruction
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            done <= 1'b0;
            pc_out <= PC_RESET;
            acc_we <= 1'b0;
            acc_out <= BYTE_RESET;
            b_we <= 1'b0;
            b_out <= BYTE_RESET;
            byte_we <= 1'b0;
            byte_out <= BYTE_RESET;
            byte_dest <= DST_ACC;
            ptr_we <= 1'b0;
            pointer_low_byte_out <= BYTE_RESET;
            pointer_high_byte_out <= BYTE_RESET;
            flags_we <= 1'b0;
            carry_out <= 1'b0;
            arith_excess_flag_out <= 1'b0;
        end else begin
            done <= finish_reg;
            pc_out <= pc_hold;
            acc_out <= acc_hold;
            b_out <= b_hold;
            byte_out <= byte_hold;
            // Destination leaves with its byte, so back-to-back results stay paired
            byte_dest <= dest_hold;
            pointer_low_byte_out <= ptr_hold[7:0];
            pointer_high_byte_out <= ptr_hold[15:8];
            acc_we <= finish_reg && acc_w_hold;
            b_we <= finish_reg && b_w_hold;
            byte_we <= finish_reg && byte_w_hold;
            ptr_we <= finish_reg && ptr_w_hold;
            flags_we <= finish_reg && flags_w_hold;
            carry_out <= 1'b0;
            arith_excess_flag_out <= excess_hold;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_div_excess: assert property (@(posedge clock) disable iff (sys_rst)
        (issue && state_reg == ST_IDLE && op_kind == OP_DIVIDE && b_in == 8'h00)
        |-> ##5 (flags_we && arith_excess_flag_out && !carry_out))
        else $error("divide by zero flags wrong");
    a_div_time: assert property (@(posedge clock) disable iff (sys_rst)
        (issue && state_reg == ST_IDLE && op_kind == OP_DIVIDE)
        |-> ##5 (done && acc_we && b_we))
        else $error("divide timing wrong");
    a_minus_wrap: assert property (@(posedge clock) disable iff (sys_rst)
        (issue && state_reg == ST_IDLE && op_kind == OP_MINUS && operand_val == 8'h00)
        |-> ##2 (byte_we && byte_out == 8'hFF && !flags_we))
        else $error("minus-one wrap wrong");
    a_plus_wrap: assert property (@(posedge clock) disable iff (sys_rst)
        (issue && state_reg == ST_IDLE && op_kind == OP_PLUS && operand_val == 8'hFF)
        |-> ##2 (byte_we && byte_out == 8'h00 && !flags_we))
        else $error("plus-one wrap wrong");
    a_ptr_carry: assert property (@(posedge clock) disable iff (sys_rst)
        (issue && state_reg == ST_IDLE && op_kind == OP_PTR && pointer_low_byte_in == 8'hFF)
        |-> ##3 (ptr_we && pointer_low_byte_out == 8'h00
            && pointer_high_byte_out == $past(pointer_high_byte_in, 3) + 8'h01))
        else $error("pointer carry wrong");
    a_loop_fall: assert property (@(posedge clock) disable iff (sys_rst)
        (issue && state_reg == ST_IDLE && op_kind == OP_LOOP && operand_val == 8'h01)
        |-> ##3 (done && pc_out == $past(next_pc, 3)))
        else $error("loop branch taken at zero");
    a_bit_taken: assert property (@(posedge clock) disable iff (sys_rst)
        (issue && state_reg == ST_IDLE && op_kind == OP_BIT && bit_in)
        |-> ##3 (done && pc_out == $past(next_pc + {{8{operand2[7]}}, operand2}, 3)))
        else $error("bit branch target wrong");
    a_bit_busy: assert property (@(posedge clock) disable iff (sys_rst)
        (issue && state_reg == ST_IDLE && op_kind == OP_BIT) |=> busy ##1 !busy)
        else $error("bit branch cycle count wrong");
endmodule

// file: src/exec_pkg.sv
package exec_pkg;
    // Opcode patterns
    localparam logic [7:0] OP_DEC_A = 8'h14;
    localparam logic [7:0] OP_DEC_DIR = 8'h15;
    localparam logic [6:0] OP_DEC_IND = 7'h0B;
    localparam logic [4:0] OP_DEC_REG = 5'h03;
    localparam logic [7:0] OP_INC_A = 8'h04;
    localparam logic [7:0] OP_INC_DIR = 8'h05;
    localparam logic [6:0] OP_INC_IND = 7'h03;
    localparam logic [4:0] OP_INC_REG = 5'h01;
    localparam logic [7:0] OP_DIV = 8'h84;
    localparam logic [4:0] OP_LOOP_REG = 5'h1B;
    localparam logic [7:0] OP_LOOP_DIR = 8'hD5;
    localparam logic [7:0] OP_INC_PTR = 8'hA3;
    localparam logic [7:0] OP_BIT_SET = 8'h20;
    // Lengths in bytes
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [15:0] LEN_THREE = 16'h0003;
    // Cycle counts
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_DIV = 3'h4;
    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

// file: tb/test_dec_inc_div_branch_exec.sv
`timescale 1ns/100ps
module test_dec_inc_div_branch_exec
    import exec_pkg::*;
;
    // ****************************************
    // Stimulus and result signals
    // ****************************************
    typedef struct {
        logic [2:0] kind;
        logic [4:0] we;
        logic [15:0] pc;
        logic [1:0] dest;
        logic [7:0] bv, av, rv;
        logic [15:0] pv;
        logic exc, abok;
        int at;
    } note_s;
    logic clock, sys_rst, issue, is_port, bit_in, carry_in, arith_excess_flag_in;
    logic [7:0] opcode, operand1, operand2, acc_in, b_in, bank_work_reg_in, mem_in;
    logic [7:0] port_latch_in, pointer_low_byte_in, pointer_high_byte_in;
    logic [15:0] pc_in, pc_out;
    logic busy, done, acc_we, b_we, byte_we, ptr_we, flags_we, carry_out;
    logic arith_excess_flag_out, illegal;
    logic [7:0] acc_out, b_out, byte_out, pointer_low_byte_out, pointer_high_byte_out;
    logic [1:0] byte_dest;
    logic [7:0] r_op, r_o1, r_o2, r_acc, r_b, r_bank, r_mem, r_latch, r_lo, r_hi;
    logic [15:0] r_pc;
    logic r_isp, r_bit, r_c, r_ov;
    logic [31:0] seed = 32'h725AAAE8;
    note_s notes[$];
    note_s mon_n;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    dec_inc_div_branch_exec dut (.*);
    // ****************************************
    // Clock, counters and helpers
    // ****************************************
    initial begin
        clock = 1'h0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Boundary values come up often, since wrap cases hide the usual slips
    function logic [7:0] rb();
        seed = xs(seed);
        case (seed[2:0])
            3'h0: return 8'h00;
            3'h1: return 8'hFF;
            3'h2: return 8'h01;
            default: return seed[15:8];
        endcase
    endfunction
    task automatic pick();
        {r_op, r_o1, r_o2, r_acc, r_b} = {rb(), rb(), rb(), rb(), rb()};
        {r_bank, r_mem, r_latch, r_lo, r_hi} = {rb(), rb(), rb(), rb(), rb()};
        r_pc = {rb(), rb()};
        {r_isp, r_bit, r_c, r_ov} = seed[19:16];
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ****************************************
    // Reference model of one instruction
    // ****************************************
    function automatic note_s model();
        note_s n;
        logic [7:0] m, s, rel;
        logic [15:0] nx;
        m = r_isp ? r_latch : r_mem;
        n = '{kind: 3'h5, we: 5'h00, pc: 16'h0, dest: 2'h0, bv: 8'h0, av: 8'h0, rv: 8'h0,
              pv: 16'h0, exc: 1'h0, abok: 1'h0, at: 0};
        if (r_op[7:5] == 3'h0 && (r_op[3] || r_op[2])) begin
            n.kind = r_op[4] ? 3'h0 : 3'h6;
            n.we = 5'h10;
            n.pc = r_pc + 16'h1;
            if (r_op[3]) begin
                s = r_bank;
                n.dest = 2'h1;
            end else if (r_op[1:0] == 2'h0) begin
                s = r_acc;
                n.dest = 2'h0;
            end else begin
                s = m;
                n.dest = (r_op[1:0] == 2'h1) ? 2'h2 : 2'h3;
                n.pc = r_pc + ((r_op[1:0] == 2'h1) ? 16'h2 : 16'h1);
            end
            n.bv = r_op[4] ? s - 8'h1 : s + 8'h1;
        end else if (r_op[7:3] == 5'h1B || r_op == 8'hD5) begin
            n.kind = 3'h1;
            n.we = 5'h10;
            n.dest = r_op[3] ? 2'h1 : 2'h2;
            n.bv = (r_op[3] ? r_bank : m) - 8'h1;
            nx = r_pc + (r_op[3] ? 16'h2 : 16'h3);
            rel = r_op[3] ? r_o1 : r_o2;
            n.pc = (n.bv != 8'h0) ? nx + {{8{rel[7]}}, rel} : nx;
        end else if (r_op == 8'h84) begin
            n = '{kind: 3'h2, we: 5'h0D, pc: r_pc + 16'h1, dest: 2'h0, bv: 8'h0, av: 8'h0,
                  rv: 8'h0, pv: 16'h0, exc: r_b == 8'h0, abok: r_b != 8'h0, at: 0};
            if (n.abok) begin
                n.av = r_acc / r_b;
                n.rv = r_acc % r_b;
            end
        end else if (r_op == 8'hA3) begin
            n.kind = 3'h3;
            n.we = 5'h02;
            n.pc = r_pc + 16'h1;
            n.pv = {r_hi, r_lo} + 16'h1;
        end else if (r_op == 8'h20) begin
            n.kind = 3'h4;
            n.pc = r_pc + 16'h3 + (r_bit ? {{8{r_o2[7]}}, r_o2} : 16'h0);
        end
        return n;
    endfunction
    // ****************************************
    // Driver: issue one instruction, note the expectation
    // ****************************************
    task automatic go(input bit keep);
        note_s n;
        @(posedge clock);
        n = model();
        n.at = cyc + 2 + ((n.kind == 3'h5) ? 0 : (n.kind == 3'h2) ? 4 :
               (n.kind == 3'h0 || n.kind == 3'h6) ? 1 : 2);
        if (keep) begin
            notes.push_back(n);
        end
        issue <= 1'h1;
        {opcode, operand1, operand2, pc_in} <= {r_op, r_o1, r_o2, r_pc};
        {acc_in, b_in, bank_work_reg_in, mem_in, port_latch_in} <= {r_acc, r_b, r_bank, r_mem,
                                                                    r_latch};
        {pointer_low_byte_in, pointer_high_byte_in} <= {r_lo, r_hi};
        {is_port, bit_in, carry_in, arith_excess_flag_in} <= {r_isp, r_bit, r_c, r_ov};
    endtask
    task automatic wait_idle(input string name);
        int i;
        @(posedge clock);
        issue <= 1'h0;
        for (i = 0; i < 40 && notes.size() != 0; i++) begin
            @(posedge clock);
        end
        if (i == 40) begin
            chk("completion wait", 16'h0, 16'h1);
            finish_test();
        end else begin
            $display("test %s finished", name);
        end
    endtask
    // ****************************************
    // Monitor: compare each completion with the oldest note
    // ****************************************
    always @(negedge clock) begin
        if (!sys_rst && (done === 1'h1 || illegal === 1'h1)) begin
            if (notes.size() == 0) begin
                chk("unrequested completion", 16'h0, 16'h1);
            end else begin
                mon_n = notes.pop_front();
                chk("latency", mon_n.at[15:0], cyc[15:0]);
                chk("illegal", {15'h0, mon_n.kind == 3'h5}, {15'h0, illegal});
                chk("done", {15'h0, mon_n.kind != 3'h5}, {15'h0, done});
                if (mon_n.kind != 3'h5) begin
                    chk("busy", 16'h0, {15'h0, busy});
                    chk("pc_out", mon_n.pc, pc_out);
                    chk("write enables", {11'h0, mon_n.we},
                        {11'h0, byte_we, acc_we, b_we, ptr_we, flags_we});
                end
                case (mon_n.kind)
                    3'h0, 3'h6: begin
                        chk("byte_dest", {14'h0, mon_n.dest}, {14'h0, byte_dest});
                        if (mon_n.kind == 3'h0) begin
                            chk("minus byte", {8'h0, mon_n.bv}, {8'h0, byte_out});
                        end else begin
                            chk("plus byte", {8'h0, mon_n.bv}, {8'h0, byte_out});
                        end
                    end
                    3'h1: begin
                        chk("loop dest", {14'h0, mon_n.dest}, {14'h0, byte_dest});
                        chk("loop byte", {8'h0, mon_n.bv}, {8'h0, byte_out});
                    end
                    3'h2: begin
                        if (mon_n.abok) begin
                            chk("quotient, remainder", {mon_n.av, mon_n.rv},
                                {acc_out, b_out});
                        end
                        chk("carry", 16'h0, {15'h0, carry_out});
                        chk("excess", {15'h0, mon_n.exc}, {15'h0, arith_excess_flag_out});
                    end
                    3'h3: chk("pointer", mon_n.pv,
                              {pointer_high_byte_out, pointer_low_byte_out});
                    default: ;
                endcase
            end
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int k;
        {sys_rst, issue, r_op} = {1'h1, 1'h0, 8'h00};
        pick();
        go(1'h0);
        @(posedge clock);
        issue <= 1'h0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'h0;
        @(posedge clock);
        #1;
        chk("outputs after reset", 16'h0, {pc_out[13:0], busy, done});
        // Known wrap cases and the port latch source
        pick();
        {r_op, r_acc} = {8'h14, 8'h00};
        go(1'h1);
        pick();
        {r_op, r_isp, r_mem, r_latch} = {8'h15, 1'h1, 8'h33, 8'h80};
        go(1'h1);
        pick();
        {r_op, r_bank} = {8'h0F, 8'hFF};
        go(1'h1);
        wait_idle("wrap cases");
        pick();
        {r_op, r_acc, r_b} = {8'h84, 8'hFB, 8'h12};
        go(1'h1);
        wait_idle("divide");
        pick();
        {r_op, r_hi, r_lo} = {8'hA3, 8'hFF, 8'hFF};
        go(1'h1);
        wait_idle("pointer wrap");
        // A request inside a divide must be dropped without a trace
        pick();
        r_op = 8'h84;
        go(1'h1);
        r_op = 8'h04;
        go(1'h0);
        @(posedge clock);
        issue <= 1'h0;
        #1;
        chk("busy in divide", 16'h1, {15'h0, busy});
        wait_idle("refused issue");
        // Every opcode twice, random operands
        for (k = 0; k < 512; k++) begin
            pick();
            r_op = k[7:0];
            go(1'h1);
            wait_idle("opcode sweep");
        end
        // One-cycle operations issued back to back
        for (k = 0; k < 24; k++) begin
            pick();
            r_op = {3'h0, seed[24:20]};
            r_op[2] = r_op[2] | ~r_op[3];
            go(1'h1);
        end
        wait_idle("back to back");
        finish_test();
    end
endmodule
